/* File: rtl/cio_pkg.sv */
// constants, register map and types for the camera control i/o block
// assumes a 100 mhz hclk and word-aligned ahb-lite accesses
package cio_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int FILTER_UNIT_NS = 100;
   localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
   localparam int UNIT_CYCLES = FILTER_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
   localparam logic [3:0] UNIT_MUL = 4'(UNIT_CYCLES);

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FILTER = 8'h04;
   localparam logic [7:0] OFS_TIMER = 8'h08;
   localparam logic [7:0] OFS_DELAY = 8'h0c;
   localparam logic [7:0] OFS_DURATION = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int CTRL_PICK = 0;
   localparam int CTRL_FLIP = 1;
   localparam int CTRL_DRV_LO = 2;
   localparam int CTRL_DIR = 5;
   localparam int CTRL_SWLVL = 8;
   localparam int TIMER_SRC_LO = 0;
   localparam int TIMER_ACT_LO = 2;
   localparam logic [23:0] FILTER_RESET = 24'h000005;
   localparam logic [23:0] FILTER_MAX = 24'h989680;
   localparam logic [25:0] TIME_MAX = 26'h3938700;
   localparam logic [25:0] DURATION_RESET = 26'h0000001;
   localparam logic [25:0] DURATION_MIN = 26'h0000001;

   // ****************************************
   // enumerations
   // ****************************************
   typedef enum logic [2:0] {
      DRV_OFF = 3'h0,
      DRV_EXPOSURE = 3'h1,
      DRV_READOUT = 3'h2,
      DRV_SOFTWARE = 3'h3,
      DRV_TIMER = 3'h4
   } cio_drv_e;

   typedef enum logic [1:0] {
      TSRC_OFF = 2'h0,
      TSRC_EXPOSURE = 2'h1,
      TSRC_READOUT = 2'h2,
      TSRC_TRIGGER = 2'h3
   } cio_tsrc_e;

   typedef enum logic [1:0] {
      TACT_RISE = 2'h0,
      TACT_FALL = 2'h1,
      TACT_HIGH = 2'h2,
      TACT_LOW = 2'h3
   } cio_tact_e;

   typedef enum logic [1:0] {
      TST_IDLE = 2'h0,
      TST_DELAY = 2'h1,
      TST_ACTIVE = 2'h2
   } cio_tst_e;
endpackage : cio_pkg

/* File: rtl/cio_filter_if.sv */
// link between the control i/o top and its glitch filter
// assumes both ends share hclk
`timescale 1ns/100ps
`default_nettype none
interface cio_filter_if;
   logic raw;
   logic [27:0] span;
   logic clean;
   modport owner (output raw, output span, input clean);
   modport filter (input raw, input span, output clean);
endinterface : cio_filter_if
`default_nettype wire

/* File: rtl/cio_glitch_filter.sv */
// glitch filter for the trigger input line
// assumes raw is already synchronous to hclk; span is the interval in cycles
`timescale 1ns/100ps
`default_nettype none
module cio_glitch_filter (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // filter link
   cio_filter_if.filter fl
);
   typedef struct packed {
      logic stable;
      logic [27:0] cnt;
   } cio_flt_s;

   cio_flt_s st_q;
   cio_flt_s st_d;

   always_comb begin
      st_d = st_q;
      if (fl.raw == st_q.stable) begin
         st_d.cnt = 28'h0000000;
      end else if (st_q.cnt + 28'h0000001 >= fl.span) begin
         st_d.stable = fl.raw;
         st_d.cnt = 28'h0000000;
      end else begin
         st_d.cnt = st_q.cnt + 28'h0000001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // zero interval bypasses the counter entirely
   assign fl.clean = (fl.span == 28'h0000000) ? fl.raw : st_q.stable;

   // ****************************************
   // checks
   // ****************************************
   chk_flt_level_held: assert property (@(posedge hclk) disable iff (!hresetn)
      (fl.span != 28'h0000000 && $stable(fl.span) && st_q.stable != $past(st_q.stable))
      |-> ($past(st_q.cnt) + 28'h0000001 >= fl.span && $past(fl.raw) == st_q.stable))
      else $error("filtered level changed before the interval elapsed");
   chk_flt_short_drop: assert property (@(posedge hclk) disable iff (!hresetn)
      (fl.raw == st_q.stable) |=> (st_q.cnt == 28'h0000000 && $stable(st_q.stable)))
      else $error("short pulse was not discarded");
   chk_flt_bypass: assert property (@(posedge hclk) disable iff (!hresetn)
      (fl.span == 28'h0000000) |-> (fl.clean == fl.raw))
      else $error("zero interval did not pass input through");
endmodule : cio_glitch_filter
`default_nettype wire

/* File: rtl/cio_top.sv */
// control i/o block: filtered trigger input, selectable strobe output, timer
// assumes an ahb-lite master on hclk and exposure/readout windows from sensor timing
// Contract
// - the trigger input line is input only and reports only the input direction.
// - the strobe output line is output only and reports only the output direction.
// - with polarity flip set the strobe line carries the complement of the chosen source.
// - with the driver choice off nothing is driven onto the strobe line.
// - the exposure choice puts the exposure window of each frame on the line.
// - the readout choice puts the frame readout window on the line.
// - the software choice drives the line from the value software set.
// - a false software level drives low and a true one drives high.
// - the timer choice drives the line with the configured timer signal.
// - the exposure window rises when exposure begins and falls when it ends.
// - the filter interval spans 0 to 1,000,000 us and resets to 0.5 us.
// - a new input level is taken only after it held for the filter interval.
// - input pulses shorter than the filter interval never reach internal logic.
// - a valid input change takes effect after a delay equal to the interval.
// - the timer triggers from the exposure window, readout window or trigger input.
`timescale 1ns/100ps
`default_nettype none
module cio_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // sensor timing
   input wire logic exposure_window,
   input wire logic readout_window,
   // pins
   input wire logic trigger_input_line,
   output logic strobe_output_line,
   output logic strobe_output_oe_n,
   // filtered trigger to the core
   output logic trigger_clean
);
   typedef struct packed {
      logic wr_pend;
      logic [7:0] addr;
      logic line_pick;
      logic polarity_flip;
      cio_pkg::cio_drv_e output_driver_choice;
      logic software_level;
      logic [23:0] glitch_filter_interval;
      cio_pkg::cio_tsrc_e tsrc;
      cio_pkg::cio_tact_e tact;
      logic [25:0] tdelay;
      logic [25:0] tdur;
      logic [31:0] rdata;
      cio_pkg::cio_tst_e tst;
      logic [25:0] tcnt;
      logic [6:0] usdiv;
      logic prev_src;
      logic strobe;
      logic drive;
   } cio_top_state_s;

   cio_top_state_s st_q;
   cio_top_state_s st_d;
   logic take;
   logic us_tick;
   logic tsig;
   logic tcond;
   logic tstart;
   logic tout;
   logic srcsel;
   logic [31:0] rd_mux;
   logic [31:0] ctrl_word;

   cio_filter_if fl ();

   cio_glitch_filter u_filter (
      .hclk(hclk),
      .hresetn(hresetn),
      .fl(fl)
   );

   assign fl.raw = trigger_input_line;
   assign fl.span = 28'(st_q.glitch_filter_interval * cio_pkg::UNIT_MUL);

   // ****************************************
   // bus decode
   // ****************************************
   assign take = hsel && htrans[1] && hready;
   assign us_tick = (st_q.usdiv == cio_pkg::US_LAST);

   always_comb begin
      ctrl_word = 32'h00000000;
      ctrl_word[cio_pkg::CTRL_PICK] = st_q.line_pick;
      ctrl_word[cio_pkg::CTRL_FLIP] = st_q.polarity_flip;
      ctrl_word[cio_pkg::CTRL_DRV_LO +: 3] = st_q.output_driver_choice;
      // direction follows the picked line and cannot be written
      ctrl_word[cio_pkg::CTRL_DIR] = st_q.line_pick;
      ctrl_word[cio_pkg::CTRL_SWLVL] = st_q.software_level;
   end

   always_comb begin
      case (haddr[7:0])
         cio_pkg::OFS_CTRL: rd_mux = ctrl_word;
         cio_pkg::OFS_FILTER: rd_mux = {8'h00, st_q.glitch_filter_interval};
         cio_pkg::OFS_TIMER: rd_mux = {28'h0000000, st_q.tact, st_q.tsrc};
         cio_pkg::OFS_DELAY: rd_mux = {6'h00, st_q.tdelay};
         cio_pkg::OFS_DURATION: rd_mux = {6'h00, st_q.tdur};
         cio_pkg::OFS_STATUS: rd_mux = {26'h0000000, st_q.drive, tout, readout_window,
                                        exposure_window, st_q.strobe, fl.clean};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // ****************************************
   // timer source and trigger
   // ****************************************
   always_comb begin
      case (st_q.tsrc)
         cio_pkg::TSRC_EXPOSURE: tsig = exposure_window;
         cio_pkg::TSRC_READOUT: tsig = readout_window;
         cio_pkg::TSRC_TRIGGER: tsig = fl.clean;
         default: tsig = 1'b0;
      endcase
   end

   always_comb begin
      case (st_q.tact)
         cio_pkg::TACT_RISE: tstart = tsig && !st_q.prev_src;
         cio_pkg::TACT_FALL: tstart = !tsig && st_q.prev_src;
         cio_pkg::TACT_HIGH: tstart = tsig;
         default: tstart = !tsig;
      endcase
   end

   // level modes hold the output only while the level lasts
   assign tcond = (st_q.tact == cio_pkg::TACT_HIGH) ? tsig :
                  (st_q.tact == cio_pkg::TACT_LOW) ? !tsig : 1'b1;
   assign tout = (st_q.tst == cio_pkg::TST_ACTIVE) && tcond;

   always_comb begin
      case (st_q.output_driver_choice)
         cio_pkg::DRV_EXPOSURE: srcsel = exposure_window;
         cio_pkg::DRV_READOUT: srcsel = readout_window;
         cio_pkg::DRV_SOFTWARE: srcsel = st_q.software_level;
         cio_pkg::DRV_TIMER: srcsel = tout;
         default: srcsel = 1'b0;
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      st_d.wr_pend = take && hwrite;
      if (take) begin
         st_d.addr = haddr[7:0];
      end
      // read data is registered in the address phase so hrdata is a flop
      st_d.rdata = (take && !hwrite) ? rd_mux : st_q.rdata;
      if (st_q.wr_pend) begin
         case (st_q.addr)
            cio_pkg::OFS_CTRL: begin
               st_d.line_pick = hwdata[cio_pkg::CTRL_PICK];
               st_d.polarity_flip = hwdata[cio_pkg::CTRL_FLIP];
               st_d.output_driver_choice = (hwdata[cio_pkg::CTRL_DRV_LO +: 3] > cio_pkg::DRV_TIMER) ?
                  cio_pkg::DRV_OFF : cio_pkg::cio_drv_e'(hwdata[cio_pkg::CTRL_DRV_LO +: 3]);
               st_d.software_level = hwdata[cio_pkg::CTRL_SWLVL];
            end
            cio_pkg::OFS_FILTER: begin
               st_d.glitch_filter_interval = (hwdata[31:0] > {8'h00, cio_pkg::FILTER_MAX}) ?
                  cio_pkg::FILTER_MAX : hwdata[23:0];
            end
            cio_pkg::OFS_TIMER: begin
               st_d.tsrc = cio_pkg::cio_tsrc_e'(hwdata[cio_pkg::TIMER_SRC_LO +: 2]);
               st_d.tact = cio_pkg::cio_tact_e'(hwdata[cio_pkg::TIMER_ACT_LO +: 2]);
            end
            cio_pkg::OFS_DELAY: begin
               st_d.tdelay = (hwdata > {6'h00, cio_pkg::TIME_MAX}) ? cio_pkg::TIME_MAX : hwdata[25:0];
            end
            cio_pkg::OFS_DURATION: begin
               st_d.tdur = (hwdata > {6'h00, cio_pkg::TIME_MAX}) ? cio_pkg::TIME_MAX :
                           (hwdata[25:0] < cio_pkg::DURATION_MIN) ? cio_pkg::DURATION_MIN : hwdata[25:0];
            end
            default: begin
            end
         endcase
      end
      // microsecond prescaler for the timer delay and duration
      st_d.usdiv = us_tick ? 7'h00 : st_q.usdiv + 7'h01;
      st_d.prev_src = tsig;
      case (st_q.tst)
         cio_pkg::TST_IDLE: begin
            st_d.tcnt = 26'h0000000;
            if (st_q.tsrc != cio_pkg::TSRC_OFF && tstart) begin
               st_d.tst = (st_q.tdelay == 26'h0000000) ? cio_pkg::TST_ACTIVE : cio_pkg::TST_DELAY;
            end
         end
         cio_pkg::TST_DELAY: begin
            if (us_tick) begin
               st_d.tcnt = st_q.tcnt + 26'h0000001;
               if (st_q.tcnt + 26'h0000001 >= st_q.tdelay) begin
                  st_d.tst = cio_pkg::TST_ACTIVE;
                  st_d.tcnt = 26'h0000000;
               end
            end
         end
         cio_pkg::TST_ACTIVE: begin
            if (st_q.tact == cio_pkg::TACT_HIGH || st_q.tact == cio_pkg::TACT_LOW) begin
               if (!tcond) begin
                  st_d.tst = cio_pkg::TST_IDLE;
               end
            end else if (us_tick) begin
               st_d.tcnt = st_q.tcnt + 26'h0000001;
               if (st_q.tcnt + 26'h0000001 >= st_q.tdur) begin
                  st_d.tst = cio_pkg::TST_IDLE;
               end
            end
         end
         default: st_d.tst = cio_pkg::TST_IDLE;
      endcase
      // switching the timer off abandons any run in progress
      if (st_q.tsrc == cio_pkg::TSRC_OFF) begin
         st_d.tst = cio_pkg::TST_IDLE;
      end
      st_d.strobe = (st_q.output_driver_choice == cio_pkg::DRV_OFF) ? 1'b0 :
                    srcsel ^ st_q.polarity_flip;
      st_d.drive = (st_q.output_driver_choice != cio_pkg::DRV_OFF);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
         st_q.glitch_filter_interval <= cio_pkg::FILTER_RESET;
         st_q.tdur <= cio_pkg::DURATION_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_q.rdata;
   assign strobe_output_line = st_q.strobe;
   assign strobe_output_oe_n = !st_q.drive;
   assign trigger_clean = fl.clean;

   // ****************************************
   // checks
   // ****************************************
   sequence s_picked(cio_pkg::cio_drv_e c);
      st_q.output_driver_choice == c ##1 st_q.output_driver_choice == c;
   endsequence

   chk_drv_off_release: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q.output_driver_choice == cio_pkg::DRV_OFF) |=> (strobe_output_oe_n && !strobe_output_line))
      else $error("strobe line driven while the driver choice is off");
   chk_sw_level_out: assert property (@(posedge hclk) disable iff (!hresetn)
      s_picked(cio_pkg::DRV_SOFTWARE) |-> (strobe_output_line == ($past(st_q.software_level) ^
      $past(st_q.polarity_flip)) && !strobe_output_oe_n))
      else $error("software level not on strobe line");
   chk_exposure_out: assert property (@(posedge hclk) disable iff (!hresetn)
      s_picked(cio_pkg::DRV_EXPOSURE) |-> strobe_output_line == ($past(exposure_window) ^
      $past(st_q.polarity_flip)))
      else $error("exposure window not on strobe line");
   chk_readout_out: assert property (@(posedge hclk) disable iff (!hresetn)
      s_picked(cio_pkg::DRV_READOUT) |-> strobe_output_line == ($past(readout_window) ^
      $past(st_q.polarity_flip)))
      else $error("readout window not on strobe line");
   chk_timer_out: assert property (@(posedge hclk) disable iff (!hresetn)
      s_picked(cio_pkg::DRV_TIMER) |-> strobe_output_line == ($past(tout) ^ $past(st_q.polarity_flip)))
      else $error("timer signal not on strobe line");
   chk_dir_report: assert property (@(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr[7:0] == cio_pkg::OFS_CTRL) |=> hrdata[cio_pkg::CTRL_DIR] == hrdata[cio_pkg::CTRL_PICK])
      else $error("line direction does not follow the picked line");
   chk_timer_off_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q.tsrc == cio_pkg::TSRC_OFF) |=> (st_q.tst == cio_pkg::TST_IDLE && !tout))
      else $error("timer ran without a trigger source");

   sequence s_delay_wait;
      st_q.tst == cio_pkg::TST_DELAY && !us_tick && st_q.tsrc != cio_pkg::TSRC_OFF;
   endsequence
   chk_delay_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      s_delay_wait |=> st_q.tst == cio_pkg::TST_DELAY)
      else $error("timer left its delay between microsecond ticks");
   chk_drv_code_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q.wr_pend && st_q.addr == cio_pkg::OFS_CTRL && hwdata[cio_pkg::CTRL_DRV_LO +: 3] > cio_pkg::DRV_TIMER)
      |=> (st_q.output_driver_choice == cio_pkg::DRV_OFF))
      else $error("unknown driver code was not turned off");
   chk_filter_range: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q.wr_pend && st_q.addr == cio_pkg::OFS_FILTER |=> st_q.glitch_filter_interval <= cio_pkg::FILTER_MAX)
      else $error("filter interval above its range");
endmodule : cio_top
`default_nettype wire

/* File: dv/cio_partner.sv */
// far-side model: external trigger source and strobe receiver
// assumes the bench clock; the receiver input has a pull-down
`timescale 1ns/100ps
`default_nettype none
module cio_partner (
   // clock
   input wire logic hclk,
   // pins
   output logic trigger_input_line,
   input wire logic strobe_output_line,
   input wire logic strobe_output_oe_n,
   // level seen at the receiver
   output logic strobe_seen
);
   // an undriven pin falls to the pull-down, not to the last driven value
   assign strobe_seen = strobe_output_oe_n ? 1'b0 : strobe_output_line;
   initial trigger_input_line = 1'b0;

   // called just after a rising edge: drive a level and hold it n cycles
   task automatic level(input logic v, input int n);
      trigger_input_line <= v;
      repeat (n) @(posedge hclk);
   endtask : level
endmodule : cio_partner
`default_nettype wire

/* File: dv/cio_top_tb.sv */
// self-checking bench for the control i/o block
// assumes zero-wait ahb-lite answers and the partner model on the pins
`timescale 1ns/100ps
`default_nettype none
module cio_top_tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic exposure_window, readout_window, trigger_input_line;
   logic strobe_output_line, strobe_output_oe_n, trigger_clean, strobe_seen;
   int n_errors = 0;
   int n_tests = 0;

   cio_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .exposure_window(exposure_window),
      .readout_window(readout_window), .trigger_input_line(trigger_input_line),
      .strobe_output_line(strobe_output_line), .strobe_output_oe_n(strobe_output_oe_n),
      .trigger_clean(trigger_clean));
   cio_partner partner (.hclk(hclk), .trigger_input_line(trigger_input_line),
      .strobe_output_line(strobe_output_line), .strobe_output_oe_n(strobe_output_oe_n),
      .strobe_seen(strobe_seen));

   // ****************************************
   // clock, reset and bus tasks
   // ****************************************
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic cmp_word(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] r;
      bus(1'b0, a, 32'h00000000, r);
      n_tests++;
      if (r !== e) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, r, e);
      end
   endtask : cmp_word

   // samples mid-cycle so the edge's updates have landed, then returns on an edge
   task automatic cmp_pin(ref logic s, input logic e, input string m);
      @(negedge hclk);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch at %0t: %s got %b expected %b", $time, m, s, e);
      end
      @(posedge hclk);
   endtask : cmp_pin

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      cmp_word(cio_pkg::OFS_CTRL, 32'h00000000, "ctrl reset");
      cmp_word(cio_pkg::OFS_FILTER, 32'h00000005, "filter reset");
      cmp_word(cio_pkg::OFS_TIMER, 32'h00000000, "timer reset");
      cmp_word(cio_pkg::OFS_DELAY, 32'h00000000, "delay reset");
      cmp_word(cio_pkg::OFS_DURATION, 32'h00000001, "duration reset");
      cmp_word(8'h40, 32'h00000000, "unmapped read");
      cmp_pin(strobe_output_oe_n, 1'b1, "strobe idle");
      cmp_pin(hresp, 1'b0, "okay response");
      $display("test reset done");
   endtask : t_reset

   task automatic t_direction;
      wr(cio_pkg::OFS_CTRL, 32'h00000020);
      cmp_word(cio_pkg::OFS_CTRL, 32'h00000000, "trigger line direction");
      wr(cio_pkg::OFS_CTRL, 32'h00000001);
      cmp_word(cio_pkg::OFS_CTRL, 32'h00000021, "strobe line direction");
      $display("test direction done");
   endtask : t_direction

   // choices off, exposure, readout and software each get the opposite level on every other source except the timer
   task automatic t_sources;
      logic e;
      for (int f = 0; f < 2; f++) begin
         for (int c = 0; c < 4; c++) begin
            for (int v = 0; v < 2; v++) begin
               e = 1'(v ^ f);
               wr(cio_pkg::OFS_CTRL, 32'(((c == 3 ? v : 1 - v) << 8) | (c << 2) | (f << 1)));
               exposure_window <= 1'(c == 1 ? v : 1 - v);
               readout_window <= 1'(c == 2 ? v : 1 - v);
               cyc(4);
               if (c == 0) cmp_pin(strobe_output_oe_n, 1'b1, "choice off");
               else cmp_pin(strobe_seen, e, "strobe level");
            end
         end
      end
      $display("test sources done");
   endtask : t_sources

   // interval 5 is 50 cycles
   task automatic t_filter;
      cmp_pin(trigger_clean, 1'b0, "filter idle");
      partner.level(1'b1, 40);
      partner.level(1'b0, 60);
      cmp_pin(trigger_clean, 1'b0, "short high pulse");
      partner.level(1'b1, 49);
      cmp_pin(trigger_clean, 1'b0, "before interval");
      cmp_pin(trigger_clean, 1'b1, "after interval");
      partner.level(1'b0, 30);
      partner.level(1'b1, 80);
      cmp_pin(trigger_clean, 1'b1, "short low pulse");
      wr(cio_pkg::OFS_FILTER, 32'hffffffff);
      cmp_word(cio_pkg::OFS_FILTER, 32'h00989680, "interval clamp");
      wr(cio_pkg::OFS_FILTER, 32'h00000000);
      partner.level(1'b0, 1);
      cmp_pin(trigger_clean, 1'b0, "zero interval low");
      partner.level(1'b1, 1);
      cmp_pin(trigger_clean, 1'b1, "zero interval high");
      partner.level(1'b0, 1);
      $display("test filter done");
   endtask : t_filter

   // level-high timer, no delay; source 0 must never fire
   task automatic t_timer;
      wr(cio_pkg::OFS_CTRL, 32'h00000010);
      for (int s = 0; s < 4; s++) begin
         wr(cio_pkg::OFS_TIMER, 32'(8 | s));
         exposure_window <= 1'b1;
         readout_window <= 1'b1;
         partner.level(1'b1, 250);
         cmp_pin(strobe_seen, 1'(s != 0), "timer active");
         exposure_window <= 1'b0;
         readout_window <= 1'b0;
         partner.level(1'b0, 250);
         cmp_pin(strobe_seen, 1'b0, "timer released");
      end
      // level-low on the readout window, then switch the timer off before the window drops
      wr(cio_pkg::OFS_TIMER, 32'h0000000e);
      cyc(4);
      cmp_pin(strobe_seen, 1'b1, "level low active");
      readout_window <= 1'b1;
      cyc(4);
      cmp_pin(strobe_seen, 1'b0, "level low released");
      wr(cio_pkg::OFS_TIMER, 32'h00000000);
      readout_window <= 1'b0;
      $display("test timer done");
   endtask : t_timer

   // rising then falling edge, 2 us delay and 3 us pulse; the free prescaler adds up to 1 us of phase
   task automatic t_timer_edge;
      wr(cio_pkg::OFS_DELAY, 32'h00000002);
      wr(cio_pkg::OFS_DURATION, 32'h00000003);
      for (int a = 0; a < 2; a++) begin
         wr(cio_pkg::OFS_TIMER, 32'((a << 2) | 1));
         exposure_window <= 1'(a);
         cyc(5);
         exposure_window <= 1'(1 - a);
         cyc(90);
         exposure_window <= 1'b0;
         cmp_pin(strobe_seen, 1'b0, "timer in delay");
         cyc(120);
         cmp_pin(strobe_seen, 1'b1, "timer pulse");
         cmp_word(cio_pkg::OFS_STATUS, 32'h00000032, "status in pulse");
         cyc(300);
         cmp_pin(strobe_seen, 1'b0, "timer pulse ended");
      end
      wr(cio_pkg::OFS_DELAY, 32'hffffffff);
      cmp_word(cio_pkg::OFS_DELAY, 32'h03938700, "delay clamp");
      wr(cio_pkg::OFS_DURATION, 32'h00000000);
      cmp_word(cio_pkg::OFS_DURATION, 32'h00000001, "duration floor");
      wr(cio_pkg::OFS_CTRL, 32'h0000001c);
      cmp_word(cio_pkg::OFS_CTRL, 32'h00000000, "driver code refused");
      cmp_pin(strobe_output_oe_n, 1'b1, "refused code released");
      $display("test timer edge done");
   endtask : t_timer_edge

   // ****************************************
   // sequence, watchdog and verdict
   // ****************************************
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      exposure_window = 1'b0;
      readout_window = 1'b0;
      cyc(4);
      hresetn <= 1'b1;
      t_reset();
      t_direction();
      t_sources();
      t_filter();
      t_timer();
      t_timer_edge();
      tally_and_finish();
   end

   // the run needs a few thousand cycles; this allows fifty thousand
   initial begin
      #500000;
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : cio_top_tb
`default_nettype wire
